// *** inc/odpp_pkg.sv ***
// Package of constants and carrier types for the open-drain port pair
package odpp_pkg;
	// Data-memory and register-file addresses
	localparam logic [6:0] QUAD_DATA_ADDR = 7'h73;
	localparam logic [6:0] PAIR_DATA_ADDR = 7'h6F;
	localparam logic [6:0] PAIR_DIR_ADDR = 7'h32;
	localparam logic [6:0] QUAD_DIR_ADDR = 7'h33;
	localparam logic [6:0] SERIAL_CTRL_ADDR = 7'h0A;
	localparam logic [6:0] TIMER_CTRL_ADDR = 7'h12;
	// Field positions
	localparam int TAKEOVER_BIT = 0;
	localparam int SCK_PIN = 0;
	localparam int SO_PIN = 1;
	localparam int SI_PIN = 2;
	localparam int TMR_PIN = 3;
	localparam int REF_PIN = 1;
	// Reset values and the pair high-bit read value
	localparam logic [3:0] QUAD_LATCH_RST = 4'h0;
	localparam logic [3:0] QUAD_DIR_RST = 4'h0;
	localparam logic [1:0] PAIR_LATCH_RST = 2'h0;
	localparam logic [1:0] PAIR_DIR_RST = 2'h0;
	localparam logic TOGGLE_RST = 1'b1;
	localparam logic [3:0] PAIR_HIGH_READ = 4'h0;
	// Reference selections below this value keep the pin as a port
	localparam logic [3:0] REF_EXTERNAL_SEL = 4'h8;

	// One core access to data memory or the register file
	typedef struct packed {
		logic wr;
		logic rd_rf;
		logic rd_dm;
		logic [6:0] addr;
		logic [3:0] wdata;
	} odpp_access_type;

	// Signals from the serial and timer blocks
	typedef struct packed {
		logic sck_out;
		logic sck_internal;
		logic so_out;
		logic timer_reset;
		logic timer_match;
	} odpp_alt_type;
endpackage

// *** core/odpp_toggle.sv ***
// Timer toggle output flip-flop
`timescale 1ns/10ps
module odpp_toggle (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Timer events
	input wire logic timer_reset,
	input wire logic timer_match,
	// Toggle level
	output logic toggle_out
);
	logic toggle_reg;
	logic toggle_next;

	assign toggle_next = timer_reset ? 1'b1 : (timer_match ? ~toggle_reg : toggle_reg);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			toggle_reg <= odpp_pkg::TOGGLE_RST;
		end else begin
			toggle_reg <= toggle_next;
		end
	end

	assign toggle_out = toggle_reg;

	AST_TOGGLE_SET: assert property (@(posedge clock) disable iff (sys_rst)
		timer_reset |=> toggle_out)
		else $error("toggle not set after timer reset");
	AST_TOGGLE_FLIP: assert property (@(posedge clock) disable iff (sys_rst)
		(timer_match && !timer_reset) |=> (toggle_out != $past(toggle_out)))
		else $error("toggle not inverted on match");
endmodule

// *** core/odpp_pin_drive.sv ***
// Open-drain low-side driver for one pin group
`timescale 1ns/10ps
module odpp_pin_drive #(
	parameter int W = 4
) (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Drive request
	input wire logic [W-1:0] drive_en,
	input wire logic [W-1:0] drive_val,
	// Pin side
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe_n
);
	logic [W-1:0] oe_n_next;

	assign oe_n_next = ~(drive_en & ~drive_val);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_oe_n <= '1;
		end else begin
			pin_oe_n <= oe_n_next;
		end
	end

	assign pin_out = '0;
endmodule

// *** core/odpp_port_pair.sv ***
// Open-drain quad port and pair port with shared-pin selection
//
// Summary of operation
// - Quad port latch at data address 73H
// - Pins are open-drain, pull low only
// - Direction 0 makes input, read pin
// - Direction 1 drives latch, reads latch
// - Reset clears quad direction and latch
// - Direction change keeps latch value
// - Serial enable takes pins zero to two
// - Timer select takes pin three
// - Timer output set, toggles on match
// - Alternate-mode reads per pin function
// - Pair port latch at address 6FH
// - Pair direction bits at 32H
// - Pair port reads always pin levels
// - Reset clears pair direction and latch
// - Pair bits two, three ignored, zero
// - Input-mode pair writes are ignored
// - Reference select takes pair pin one
`timescale 1ns/10ps
module odpp_port_pair (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Core access
	input wire odpp_pkg::odpp_access_type acc,
	output logic [3:0] rdata,
	// Serial, timer and comparator
	input wire odpp_pkg::odpp_alt_type alt,
	input wire logic [3:0] comparator_reference_select,
	input wire logic so_latch_load,
	output logic serial_data_in,
	output logic ext_sck_in,
	output logic reference_pin_selected,
	// Quad pins
	input wire logic [3:0] quad_pin_in,
	output logic [3:0] quad_pin_out,
	output logic [3:0] quad_pin_oe_n,
	// Pair pins
	input wire logic [1:0] pair_pin_in,
	output logic [1:0] pair_pin_out,
	output logic [1:0] pair_pin_oe_n
);
	logic [3:0] quad_latch_reg;
	logic [3:0] quad_latch_next;
	logic [3:0] quad_dir_reg;
	logic [3:0] quad_dir_next;
	logic [1:0] pair_latch_reg;
	logic [1:0] pair_latch_next;
	logic [1:0] pair_dir_reg;
	logic [1:0] pair_dir_next;
	logic serial_take_reg;
	logic serial_take_next;
	logic timer_take_reg;
	logic timer_take_next;
	logic [3:0] rdata_next;
	logic toggle_level;
	logic ref_sel_reg;
	logic wire_ref_sel;

	function automatic logic hit(input odpp_pkg::odpp_access_type a, input logic [6:0] addr);
		hit = a.wr && (a.addr == addr);
	endfunction

	function automatic logic dm_rd(input odpp_pkg::odpp_access_type a, input logic [6:0] addr);
		dm_rd = a.rd_dm && (a.addr == addr);
	endfunction

	function automatic logic rf_rd(input odpp_pkg::odpp_access_type a, input logic [6:0] addr);
		rf_rd = a.rd_rf && (a.addr == addr);
	endfunction

	wire wr_quad = hit(acc, odpp_pkg::QUAD_DATA_ADDR);
	wire wr_pair = hit(acc, odpp_pkg::PAIR_DATA_ADDR);
	wire wr_qdir = hit(acc, odpp_pkg::QUAD_DIR_ADDR);
	wire wr_pdir = hit(acc, odpp_pkg::PAIR_DIR_ADDR);
	wire wr_sio = hit(acc, odpp_pkg::SERIAL_CTRL_ADDR);
	wire wr_tmr = hit(acc, odpp_pkg::TIMER_CTRL_ADDR);
	wire rd_quad = dm_rd(acc, odpp_pkg::QUAD_DATA_ADDR);
	wire rd_pair = dm_rd(acc, odpp_pkg::PAIR_DATA_ADDR);
	wire rd_qdir = rf_rd(acc, odpp_pkg::QUAD_DIR_ADDR);
	wire rd_pdir = rf_rd(acc, odpp_pkg::PAIR_DIR_ADDR);
	wire rd_sio = rf_rd(acc, odpp_pkg::SERIAL_CTRL_ADDR);
	wire rd_tmr = rf_rd(acc, odpp_pkg::TIMER_CTRL_ADDR);

	// direction never touches latch
	// Serial shifting rewrites the data-out latch bit, so it must be refreshed afterwards
	assign quad_latch_next = wr_quad ? acc.wdata :
		{quad_latch_reg[3:2], so_latch_load ? alt.so_out : quad_latch_reg[1], quad_latch_reg[0]};
	assign quad_dir_next = wr_qdir ? acc.wdata : quad_dir_reg;
	assign pair_latch_next = wr_pair ?
		((acc.wdata[1:0] & pair_dir_reg) | (pair_latch_reg & ~pair_dir_reg)) : pair_latch_reg;
	assign pair_dir_next = wr_pdir ? acc.wdata[1:0] : pair_dir_reg;
	assign serial_take_next = wr_sio ? acc.wdata[odpp_pkg::TAKEOVER_BIT] : serial_take_reg;
	assign timer_take_next = wr_tmr ? acc.wdata[odpp_pkg::TAKEOVER_BIT] : timer_take_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			quad_latch_reg <= odpp_pkg::QUAD_LATCH_RST;
			quad_dir_reg <= odpp_pkg::QUAD_DIR_RST;
			pair_latch_reg <= odpp_pkg::PAIR_LATCH_RST;
			pair_dir_reg <= odpp_pkg::PAIR_DIR_RST;
			serial_take_reg <= 1'b0;
			timer_take_reg <= 1'b0;
			rdata <= 4'h0;
			ref_sel_reg <= 1'b0;
		end else begin
			quad_latch_reg <= quad_latch_next;
			quad_dir_reg <= quad_dir_next;
			pair_latch_reg <= pair_latch_next;
			pair_dir_reg <= pair_dir_next;
			serial_take_reg <= serial_take_next;
			timer_take_reg <= timer_take_next;
			rdata <= rdata_next;
			ref_sel_reg <= wire_ref_sel;
		end
	end

	odpp_toggle u_toggle (
		.clock(clock),
		.sys_rst(sys_rst),
		.timer_reset(alt.timer_reset),
		.timer_match(alt.timer_match),
		.toggle_out(toggle_level)
	);

	wire sck_drive = alt.sck_internal;
	wire [3:0] alt_en = {timer_take_reg, serial_take_reg & 1'b0, serial_take_reg,
		serial_take_reg & sck_drive};
	wire [3:0] alt_val = {toggle_level, 1'b0, alt.so_out, alt.sck_out};
	wire [3:0] alt_own = {timer_take_reg, {3{serial_take_reg}}};
	wire [3:0] quad_en = (alt_own & alt_en) | (~alt_own & quad_dir_reg);
	wire [3:0] quad_val = (alt_own & alt_val) | (~alt_own & quad_latch_reg);

	assign wire_ref_sel = comparator_reference_select >= odpp_pkg::REF_EXTERNAL_SEL;
	wire [1:0] pair_en = pair_dir_reg & {~wire_ref_sel, 1'b1};

	odpp_pin_drive #(.W(4)) u_quad_drv (
		.clock(clock),
		.sys_rst(sys_rst),
		.drive_en(quad_en),
		.drive_val(quad_val),
		.pin_out(quad_pin_out),
		.pin_oe_n(quad_pin_oe_n)
	);
	odpp_pin_drive #(.W(2)) u_pair_drv (
		.clock(clock),
		.sys_rst(sys_rst),
		.drive_en(pair_en),
		.drive_val(pair_latch_reg),
		.pin_out(pair_pin_out),
		.pin_oe_n(pair_pin_oe_n)
	);

	// alternate read sources
	// Data-out read is undefined; the latch is returned
	wire [3:0] alt_rd_latch = {1'b1, 1'b0, 1'b1, sck_drive};
	wire [3:0] rd_latch = (alt_own & alt_rd_latch) | (~alt_own & quad_dir_reg);
	wire [3:0] quad_rd = (rd_latch & quad_latch_reg) | (~rd_latch & quad_pin_in);
	wire [3:0] pair_rd = {odpp_pkg::PAIR_HIGH_READ[3:2], pair_pin_in};

	assign rdata_next =
		rd_quad ? quad_rd :
		rd_pair ? pair_rd :
		rd_qdir ? quad_dir_reg :
		rd_pdir ? {2'h0, pair_dir_reg} :
		rd_sio ? {3'h0, serial_take_reg} :
		rd_tmr ? {3'h0, timer_take_reg} :
		4'h0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			serial_data_in <= 1'b0;
			ext_sck_in <= 1'b0;
			reference_pin_selected <= 1'b0;
		end else begin
			serial_data_in <= quad_pin_in[odpp_pkg::SI_PIN];
			ext_sck_in <= quad_pin_in[odpp_pkg::SCK_PIN];
			reference_pin_selected <= ref_sel_reg;
		end
	end

	AST_QUAD_RESET: assert property (@(posedge clock)
		sys_rst |=> (quad_dir_reg == 4'h0 && quad_latch_reg == 4'h0))
		else $error("quad port not cleared by reset");
	AST_PAIR_RESET: assert property (@(posedge clock)
		sys_rst |=> (pair_dir_reg == 2'h0 && pair_latch_reg == 2'h0))
		else $error("pair port not cleared by reset");
	AST_DIR_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_qdir && !wr_quad && !so_latch_load) |=> $stable(quad_latch_reg))
		else $error("latch changed by direction write");
	AST_PAIR_IGNORE: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_pair && pair_dir_reg == 2'h0) |=> $stable(pair_latch_reg))
		else $error("input-mode pair write stored");
	AST_PAIR_READ: assert property (@(posedge clock) disable iff (sys_rst)
		(acc.rd_dm && acc.addr == odpp_pkg::PAIR_DATA_ADDR) |=>
		(rdata == {2'h0, $past(pair_pin_in)}))
		else $error("pair read not pin level");
	AST_QUAD_OUT_READ: assert property (@(posedge clock) disable iff (sys_rst)
		(acc.rd_dm && acc.addr == odpp_pkg::QUAD_DATA_ADDR && !serial_take_reg &&
		!timer_take_reg && quad_dir_reg == 4'hF) |=> (rdata == $past(quad_latch_reg)))
		else $error("output read not latch");
	AST_QUAD_IN_READ: assert property (@(posedge clock) disable iff (sys_rst)
		(acc.rd_dm && acc.addr == odpp_pkg::QUAD_DATA_ADDR && !serial_take_reg &&
		!timer_take_reg && quad_dir_reg == 4'h0) |=> (rdata == $past(quad_pin_in)))
		else $error("input read not pin");
	AST_NO_HIGH: assert property (@(posedge clock)
		(quad_pin_out == 4'h0 && pair_pin_out == 2'h0))
		else $error("pin driven high");
	AST_TIMER_PIN: assert property (@(posedge clock) disable iff (sys_rst)
		(timer_take_reg && $stable(timer_take_reg)) |=>
		(quad_pin_oe_n[odpp_pkg::TMR_PIN] == $past(toggle_level)))
		else $error("timer pin not following toggle");
	AST_INPUT_FLOAT: assert property (@(posedge clock) disable iff (sys_rst)
		(pair_dir_reg == 2'h0) |=> (pair_pin_oe_n == 2'h3))
		else $error("input pair pin driven");

	// Reads and drives while a pin belongs to another function, and output-mode pair writes
	sequence quad_read_serial;
		rd_quad && serial_take_reg;
	endsequence
	sequence quad_read_timer;
		rd_quad && timer_take_reg;
	endsequence
	sequence serial_owned;
		serial_take_reg;
	endsequence
	sequence pair_output_write;
		wr_pair && (pair_dir_reg == 2'h3);
	endsequence

	property p_quad_write;
		@(posedge clock) disable iff (sys_rst)
		wr_quad |=> (quad_latch_reg == $past(acc.wdata));
	endproperty
	AST_QUAD_WRITE: assert property (p_quad_write)
		else $error("quad latch write lost");

	property p_quad_dir_write;
		@(posedge clock) disable iff (sys_rst)
		wr_qdir |=> (quad_dir_reg == $past(acc.wdata));
	endproperty
	AST_QUAD_DIR_WRITE: assert property (p_quad_dir_write)
		else $error("quad direction write lost");

	property p_pair_write;
		@(posedge clock) disable iff (sys_rst)
		pair_output_write |=> (pair_latch_reg == $past(acc.wdata[1:0]));
	endproperty
	AST_PAIR_WRITE: assert property (p_pair_write)
		else $error("output-mode pair write lost");

	property p_pair_dir_write;
		@(posedge clock) disable iff (sys_rst)
		wr_pdir |=> (pair_dir_reg == $past(acc.wdata[1:0]));
	endproperty
	AST_PAIR_DIR_WRITE: assert property (p_pair_dir_write)
		else $error("pair direction write lost");

	property p_pair_high;
		@(posedge clock) disable iff (sys_rst)
		rd_pair |=> (rdata[3:2] == 2'h0);
	endproperty
	AST_PAIR_HIGH: assert property (p_pair_high)
		else $error("pair upper bits not zero");

	property p_si_read;
		@(posedge clock) disable iff (sys_rst)
		quad_read_serial |=> (rdata[odpp_pkg::SI_PIN] == $past(quad_pin_in[odpp_pkg::SI_PIN]));
	endproperty
	AST_SI_READ: assert property (p_si_read)
		else $error("serial input read not pin");

	property p_sck_read;
		@(posedge clock) disable iff (sys_rst)
		(quad_read_serial ##0 alt.sck_internal) |=>
		(rdata[odpp_pkg::SCK_PIN] == $past(quad_latch_reg[odpp_pkg::SCK_PIN]));
	endproperty
	AST_SCK_READ: assert property (p_sck_read)
		else $error("internal clock read not latch");

	property p_timer_read;
		@(posedge clock) disable iff (sys_rst)
		quad_read_timer |=> (rdata[odpp_pkg::TMR_PIN] == $past(quad_latch_reg[odpp_pkg::TMR_PIN]));
	endproperty
	AST_TIMER_READ: assert property (p_timer_read)
		else $error("timer pin read not latch");

	property p_si_float;
		@(posedge clock) disable iff (sys_rst)
		serial_owned |=> quad_pin_oe_n[odpp_pkg::SI_PIN];
	endproperty
	AST_SI_FLOAT: assert property (p_si_float)
		else $error("serial input pin driven");

	property p_so_drive;
		@(posedge clock) disable iff (sys_rst)
		serial_owned |=> (quad_pin_oe_n[odpp_pkg::SO_PIN] == $past(alt.so_out));
	endproperty
	AST_SO_DRIVE: assert property (p_so_drive)
		else $error("serial data pin not following data out");

	property p_ref_release;
		@(posedge clock) disable iff (sys_rst)
		(comparator_reference_select >= odpp_pkg::REF_EXTERNAL_SEL) |=>
		pair_pin_oe_n[odpp_pkg::REF_PIN];
	endproperty
	AST_REF_RELEASE: assert property (p_ref_release)
		else $error("reference pin still driven");

	property p_pair_low;
		@(posedge clock) disable iff (sys_rst)
		(pair_dir_reg[0] && !pair_latch_reg[0]) |=> !pair_pin_oe_n[0];
	endproperty
	AST_PAIR_LOW: assert property (p_pair_low)
		else $error("pair output zero not pulled low");

	property p_quad_float;
		@(posedge clock) disable iff (sys_rst)
		(quad_dir_reg == 4'h0 && !serial_take_reg && !timer_take_reg) |=>
		(quad_pin_oe_n == 4'hF);
	endproperty
	AST_QUAD_FLOAT: assert property (p_quad_float)
		else $error("input quad pin driven");
endmodule

// *** verif/odpp_board_model.sv ***
// Board model: pull-ups on every pin and optional outside pull-downs
`timescale 1ns/10ps
module odpp_board_model (
	// Open-drain drive from the port
	input wire logic [3:0] quad_out,
	input wire logic [3:0] quad_oe_n,
	input wire logic [1:0] pair_out,
	input wire logic [1:0] pair_oe_n,
	// Pins held low by outside circuitry
	input wire logic [3:0] quad_force_low,
	input wire logic [1:0] pair_force_low,
	// Wire levels seen by the port
	output logic [3:0] quad_level,
	output logic [1:0] pair_level
);
	// pull-up wins unless someone sinks the wire; a driven 1 is never seen
	assign quad_level = ~((~quad_oe_n & ~quad_out) | quad_force_low);
	assign pair_level = ~((~pair_oe_n & ~pair_out) | pair_force_low);
endmodule

// *** verif/odpp_port_pair_test.sv ***
// Self-checking bench for the open-drain port pair
`timescale 1ns/10ps
module odpp_port_pair_test;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	odpp_pkg::odpp_access_type acc = '0;
	odpp_pkg::odpp_alt_type alt = '0;
	logic [3:0] ref_sel = 4'h0;
	logic so_load = 1'b0;
	logic [3:0] q_frc = 4'h0;
	logic [1:0] p_frc = 2'h0;
	logic [3:0] rdata, q_out, q_oe_n, q_lvl, v;
	logic [1:0] p_out, p_oe_n, p_lvl;
	logic si_in, sck_in, ref_on;
	logic rd_d1 = 1'b0;
	logic [3:0] exp_q[$];
	integer seed = 32'h2FE6;
	integer failures = 0;
	integer num_checks = 0;

	always #2.5 clock = ~clock;

	odpp_port_pair i_odpp_port_pair (.clock(clock), .sys_rst(sys_rst), .acc(acc),
		.rdata(rdata), .alt(alt), .comparator_reference_select(ref_sel),
		.so_latch_load(so_load), .serial_data_in(si_in), .ext_sck_in(sck_in),
		.reference_pin_selected(ref_on), .quad_pin_in(q_lvl), .quad_pin_out(q_out),
		.quad_pin_oe_n(q_oe_n), .pair_pin_in(p_lvl), .pair_pin_out(p_out),
		.pair_pin_oe_n(p_oe_n));
	odpp_board_model i_odpp_board_model (.quad_out(q_out), .quad_oe_n(q_oe_n),
		.pair_out(p_out), .pair_oe_n(p_oe_n), .quad_force_low(q_frc),
		.pair_force_low(p_frc), .quad_level(q_lvl), .pair_level(p_lvl));

	task automatic report(input string msg);
		failures++;
		$display("CHECK FAILED at %0t: %s", $time, msg);
	endtask
	task automatic chk_rd(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp) report("read data differs");
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp) report("pin side differs");
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One access per edge, so back-to-back calls never stretch a strobe
	task automatic op(input logic w, input logic rf, input logic [6:0] a,
		input logic [3:0] d);
		@(posedge clock);
		acc <= '{wr: w, rd_rf: rf, rd_dm: ~rf & ~w, addr: a, wdata: d};
	endtask
	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic rf, input logic [6:0] a, input logic [3:0] e);
		op(1'b0, rf, a, 4'h0);
		exp_q.push_back(e);
	endtask
	task automatic step;
		@(posedge clock);
		acc <= '0;
	endtask
	task automatic idle(input int n);
		step;
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Read data lands one cycle after the request edge
	always @(posedge clock) begin
		rd_d1 <= acc.rd_rf | acc.rd_dm;
		if (rd_d1) begin
			if (exp_q.size() == 0) report("unexpected read data");
			else chk_rd(rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		report("run timed out");
		print_verdict;
	end

	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, 4'hF);
		rd(1'b1, odpp_pkg::QUAD_DIR_ADDR, 4'h0);
		rd(1'b1, odpp_pkg::PAIR_DIR_ADDR, 4'h0);
		rd(1'b0, odpp_pkg::PAIR_DATA_ADDR, 4'h3);
		idle(3);
		chk_pin(q_oe_n, 4'hF);
		chk_pin({2'h0, p_oe_n}, 4'h3);
		$display("test reset done");
		v = 4'($random(seed));
		wr(odpp_pkg::QUAD_DIR_ADDR, 4'hF);
		wr(odpp_pkg::QUAD_DATA_ADDR, v);
		q_frc <= 4'hF;
		idle(3);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, v);
		idle(2);
		chk_pin(q_oe_n, v);
		chk_pin(q_out, 4'h0);
		chk_pin({2'h0, p_out}, 4'h0);
		wr(odpp_pkg::QUAD_DIR_ADDR, 4'h0);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, 4'h0);
		wr(odpp_pkg::QUAD_DIR_ADDR, 4'hF);
		q_frc <= 4'h0;
		idle(3);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, v);
		$display("test quad port done");
		wr(odpp_pkg::PAIR_DATA_ADDR, 4'hF);
		wr(odpp_pkg::PAIR_DIR_ADDR, 4'h3);
		idle(3);
		chk_pin({2'h0, p_oe_n}, 4'h0);
		wr(odpp_pkg::PAIR_DATA_ADDR, 4'hE);
		idle(3);
		rd(1'b0, odpp_pkg::PAIR_DATA_ADDR, 4'h2);
		wr(odpp_pkg::PAIR_DIR_ADDR, 4'h3);
		p_frc <= 2'h2;
		idle(3);
		rd(1'b0, odpp_pkg::PAIR_DATA_ADDR, 4'h0);
		idle(1);
		chk_pin({2'h0, p_oe_n}, 4'h2);
		$display("test pair port done");
		wr(odpp_pkg::QUAD_DIR_ADDR, 4'h0);
		wr(odpp_pkg::SERIAL_CTRL_ADDR, 4'h1);
		alt <= '{sck_out: 1'b0, sck_internal: 1'b1, so_out: 1'b0, default: 1'b0};
		q_frc <= 4'h4;
		idle(3);
		chk_pin(q_oe_n, 4'hC);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, {2'b10, v[1:0]});
		wr(odpp_pkg::SERIAL_CTRL_ADDR, 4'h1);
		alt.sck_internal <= 1'b0;
		alt.so_out <= 1'b1;
		so_load <= 1'b1;
		step;
		so_load <= 1'b0;
		idle(3);
		chk_pin({2'h0, sck_in, si_in}, 4'h2);
		chk_pin(q_oe_n, 4'hF);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, 4'hB);
		wr(odpp_pkg::SERIAL_CTRL_ADDR, 4'h0);
		q_frc <= 4'h0;
		wr(odpp_pkg::QUAD_DIR_ADDR, 4'hF);
		idle(3);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, {v[3:2], 1'b1, v[0]});
		wr(odpp_pkg::QUAD_DATA_ADDR, v);
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, v);
		$display("test serial takeover done");
		wr(odpp_pkg::TIMER_CTRL_ADDR, 4'h1);
		alt.timer_match <= 1'b1;
		step;
		alt.timer_match <= 1'b0;
		alt.timer_reset <= 1'b1;
		step;
		alt.timer_reset <= 1'b0;
		idle(3);
		chk_pin(q_oe_n, {1'b1, v[2:0]});
		step;
		alt.timer_match <= 1'b1;
		step;
		alt.timer_match <= 1'b0;
		idle(3);
		chk_pin(q_oe_n, {1'b0, v[2:0]});
		rd(1'b0, odpp_pkg::QUAD_DATA_ADDR, v);
		$display("test timer takeover done");
		wr(odpp_pkg::PAIR_DATA_ADDR, 4'h0);
		ref_sel <= 4'h8;
		idle(3);
		chk_pin({3'h0, ref_on}, 4'h1);
		chk_pin({2'h0, p_oe_n}, 4'h2);
		step;
		ref_sel <= 4'h7;
		idle(3);
		chk_pin({3'h0, ref_on}, 4'h0);
		chk_pin({2'h0, p_oe_n}, 4'h0);
		$display("test reference select done");
		print_verdict;
	end
endmodule
